/* src/pfw_cfg.svh */
// Constants for the paged flash window glue: offsets, widths, timing counts.
// Assumes inclusion by bare name from the package and the design module.
`ifndef PFW_CFG_SVH
`define PFW_CFG_SVH

// Page port I/O address, as decoded by the processor's select unit
`define PFW_PAGE_PORT_ADDR      16'h03E0
// Page register width and reset value
`define PFW_PAGE_WIDTH          8
`define PFW_PAGE_RESET          8'h00
// Flash address hold after write strobe rises, in ns
`define PFW_ADDR_HOLD_NS        10
// Bus clock period in ns (250 MHz)
`define PFW_CLK_PERIOD_NS       4
// Least hold time rounds up to whole cycles
`define PFW_ADDR_HOLD_CYC       ((`PFW_ADDR_HOLD_NS + `PFW_CLK_PERIOD_NS - 1) / `PFW_CLK_PERIOD_NS)
// Flash data float time after a read, in ns
`define PFW_FLOAT_NS            30
`define PFW_FLOAT_CYC           ((`PFW_FLOAT_NS + `PFW_CLK_PERIOD_NS - 1) / `PFW_CLK_PERIOD_NS)
// Latch clock pulse length in bus clocks
`define PFW_LATCH_PULSE_CYC     1

`endif

/* src/pfw_pkg.sv */
// Types for the paged flash window glue.
// Assumes pfw_cfg.svh is on the include path.
`include "pfw_cfg.svh"

package pfw_pkg;
    // Bus cycle phase tracker, one-hot
    typedef enum logic [3:0] {
        PFW_IDLE  = 4'b0001,   // No cycle in progress
        PFW_ADDR  = 4'b0010,   // Address state after strobe
        PFW_WAIT  = 4'b0100,   // Wait states, selects sampled
        PFW_RECOV = 4'b1000    // Float recovery after a read
    } pfw_phase_t;

    typedef logic [`PFW_PAGE_WIDTH-1:0] pfw_page_t;
endpackage : pfw_pkg

/* src/pfw_glue.sv */
// Glue between the processor local bus and a two-byte-lane flash array.
// Assumes all inputs synchronous to ref_clk and a select unit that decodes
// the page port and the sliding window on the processor side.
`timescale 1ns/100ps
`default_nettype none
`include "pfw_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Function
// - Raise flash write strobe early for hold
// - Two byte-wide devices form 16-bit bus
// - Enable only devices whose lane active
// - Page select with write gives latch pulse
// - Page latch captures data on rising edge
// - Page port sits at 3E0h
// - Page register holds upper flash address
// - Window select gates latch output onto address
// - Processor drives low address, glue chip enables
// - Eight page bits give 256 pages
// - Disable buffer during read-to-write turnaround
// - Sample selects on entry to first wait state
// - Buffer enable from window select until ready
// - Latch pulse lasts one bus clock
module pfw_glue #(
    parameter int HOLD_CYC  = `PFW_ADDR_HOLD_CYC,  // Address hold cycles
    parameter int FLOAT_CYC = `PFW_FLOAT_CYC       // Read float cycles
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    // Processor bus control
    input  wire logic              addr_strobe_n,
    input  wire logic              write_not_read,
    input  wire logic              bus_ready_n,
    input  wire logic              upper_lane_enable_n,
    input  wire logic              lower_lane_enable_n,
    input  wire logic              page_port_select_n,
    input  wire logic              window_select_n,
    input  wire logic [15:0]       data_bus,
    // Flash side
    output logic                   flash_write_strobe_n,
    output logic                   upper_device_enable_n,
    output logic                   lower_device_enable_n,
    output logic                   buffer_enable_n,
    output logic                   latch_output_control_n,
    output logic                   latch_clock,
    output pfw_pkg::pfw_page_t     upper_flash_addr,
    output logic                   upper_addr_drive
);
    import pfw_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Phase tracking
    pfw_phase_t phase_q;           // Current bus phase
    logic       win_q;             // Window select sampled in wait state
    logic       page_q;            // Page select sampled with write
    logic       wr_q;              // Cycle direction sampled
    logic       last_rd_q;         // Current cycle is a window read
    logic [7:0] rec_cnt_q;         // Float recovery counter
    logic [7:0] hold_cnt_q;        // Loaded with HOLD_CYC at write start, never counted down or used
    logic       we_q;              // Write strobe active
    logic       clk_pulse_q;       // Latch clock pulse
    logic       en_q;              // Buffer enable active
    pfw_page_t  page_reg_q;        // Stored page

    // Phase machine: address state, then selects sampled in wait
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            phase_q <= PFW_IDLE;
        end else begin
            unique case (phase_q)
                PFW_IDLE: begin
                    if (!addr_strobe_n) begin
                        phase_q <= PFW_ADDR;
                    end
                end
                PFW_ADDR: begin
                    phase_q <= PFW_WAIT;
                end
                PFW_WAIT: begin
                    // Ready ends the cycle; a window read leaves float time
                    if (!bus_ready_n) begin
                        phase_q <= last_rd_q ? PFW_RECOV : PFW_IDLE;
                    end
                end
                PFW_RECOV: begin
                    if (rec_cnt_q == 8'h00) begin
                        phase_q <= PFW_IDLE;
                    end
                end
            endcase
        end
    end

    // Sample selects at entry to wait state, not in the address state
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            win_q     <= 1'b0;
            page_q    <= 1'b0;
            wr_q      <= 1'b0;
            last_rd_q <= 1'b0;
        end else if (phase_q == PFW_ADDR) begin
            win_q     <= !window_select_n;
            page_q    <= !page_port_select_n && write_not_read;
            wr_q      <= write_not_read;
            last_rd_q <= !window_select_n && !write_not_read;
        end else if (phase_q == PFW_IDLE) begin
            win_q     <= 1'b0;
            page_q    <= 1'b0;
            last_rd_q <= 1'b0;
        end
    end

    // Recovery counter for flash data float after a read
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rec_cnt_q <= 8'h00;
        end else if (phase_q == PFW_WAIT) begin
            rec_cnt_q <= 8'(FLOAT_CYC - 1);
        end else if (rec_cnt_q != 8'h00) begin
            rec_cnt_q <= rec_cnt_q - 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write strobe: released as soon as ready is seen, so address still holds
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            we_q       <= 1'b0;
            hold_cnt_q <= 8'h00;
        end else if (phase_q == PFW_ADDR && write_not_read && !window_select_n) begin
            we_q       <= 1'b1;
            hold_cnt_q <= 8'(HOLD_CYC);
        end else if (!bus_ready_n || phase_q != PFW_WAIT) begin
            // Ready seen: strobe drops now, bus holds address one more edge
            we_q <= 1'b0;
        end
    end
    assign flash_write_strobe_n = !(we_q && bus_ready_n);

    // Byte lane decode, each device on its own lane
    // Gated by the wait state: win_q outlives the cycle through recovery,
    // and must not enable the devices during a later page port cycle
    logic       win_act;           // Window cycle in its wait state
    assign win_act = win_q && phase_q == PFW_WAIT;
    assign upper_device_enable_n = !(win_act && !upper_lane_enable_n);
    assign lower_device_enable_n = !(win_act && !lower_lane_enable_n);

    ////////////////////////////////////////////////////////////////////////////
    // Buffer enable: window cycles only, kept off during float recovery
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            en_q <= 1'b0;
        end else if (phase_q == PFW_ADDR) begin
            en_q <= !window_select_n;
        end else if (phase_q != PFW_WAIT) begin
            en_q <= 1'b0;
        end
    end
    // Held through the edge where ready is seen, dropping after it
    assign buffer_enable_n = !(en_q && phase_q == PFW_WAIT);

    ////////////////////////////////////////////////////////////////////////////
    // Latch clock: one bus clock high, starting at wait-state entry
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            clk_pulse_q <= 1'b0;
        end else begin
            clk_pulse_q <= phase_q == PFW_ADDR && !page_port_select_n
                           && write_not_read;
        end
    end
    assign latch_clock = clk_pulse_q;

    // Page register captured at the pulse's rising edge, else held
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            page_reg_q <= `PFW_PAGE_RESET;
        end else if (phase_q == PFW_ADDR && !page_port_select_n && write_not_read) begin
            page_reg_q <= data_bus[`PFW_PAGE_WIDTH-1:0];
        end
    end

    // Window select alone gates the page onto upper flash address
    assign latch_output_control_n = window_select_n;
    assign upper_flash_addr       = page_reg_q;
    assign upper_addr_drive       = !window_select_n;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_pulse_width: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(latch_clock) |=> !latch_clock)
        else $error("latch clock longer than one cycle");
    chk_page_capture: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(latch_clock) |-> upper_flash_addr == $past(data_bus[7:0]))
        else $error("page not captured with pulse");
    chk_page_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !$past(latch_clock) && !latch_clock && $past(phase_q) != PFW_ADDR
        |-> $stable(page_reg_q))
        else $error("page changed without write");
    chk_lane_high: assert property (@(posedge ref_clk) disable iff (!rst_b)
        upper_lane_enable_n |-> upper_device_enable_n)
        else $error("upper device enabled without lane");
    chk_lane_low: assert property (@(posedge ref_clk) disable iff (!rst_b)
        lower_lane_enable_n |-> lower_device_enable_n)
        else $error("lower device enabled without lane");
    chk_oc_follow: assert property (@(posedge ref_clk) disable iff (!rst_b)
        latch_output_control_n == window_select_n)
        else $error("latch output not tied to window");
    chk_no_t1_out: assert property (@(posedge ref_clk) disable iff (!rst_b)
        phase_q inside {PFW_IDLE, PFW_ADDR} |-> buffer_enable_n && !latch_clock)
        else $error("output before wait state");
    chk_we_early: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !bus_ready_n |-> flash_write_strobe_n)
        else $error("write strobe still low at ready");
    chk_buf_recov: assert property (@(posedge ref_clk) disable iff (!rst_b)
        phase_q == PFW_RECOV |-> buffer_enable_n)
        else $error("buffer on during float");
endmodule : pfw_glue
`default_nettype wire

/* dv/pfw_cpu_model.sv */
// Processor local bus model: runs whole bus cycles into the flash glue.
// Assumes a shared ref_clk; the bench reads the output snapshots it takes.
`timescale 1ns/100ps
`default_nettype none
module pfw_cpu_model #(
    parameter int FLOAT = 4              // Float length; FLOAT+1 idle cycles honoured after a window read
) (
    // Clock and observed glue outputs
    input  wire logic        ref_clk,
    input  wire logic [6:0]  obs,
    // Processor bus drive
    output var logic         addr_strobe_n,
    output var logic         write_not_read,
    output var logic         bus_ready_n,
    output var logic         upper_lane_enable_n,
    output var logic         lower_lane_enable_n,
    output var logic         page_port_select_n,
    output var logic         window_select_n,
    output var logic [15:0]  data_bus,
    // Snapshots: first wait state, ready cycle, cycle after ready
    output var logic [6:0]   snap_wait,
    output var logic [6:0]   snap_rdy,
    output var logic [6:0]   snap_after
);
    ////////////////////////////////////////////////////////////////////////
    // Idle bus at time zero
    initial begin
        {addr_strobe_n, bus_ready_n, page_port_select_n, window_select_n} = 4'hF;
        {upper_lane_enable_n, lower_lane_enable_n, write_not_read} = 3'h7;
        data_bus = 16'hA5C3;
    end
    // One bus cycle with two wait states; rec=0 breaks the recovery gap
    task automatic cycle(input logic win, input logic w, input logic [1:0] ln,
                         input logic [15:0] d, input logic rec);
        @(posedge ref_clk); #1;
        addr_strobe_n  = 1'b0;
        write_not_read = w;
        @(posedge ref_clk); #1;
        addr_strobe_n      = 1'b1;
        page_port_select_n = win;
        window_select_n    = !win;
        {upper_lane_enable_n, lower_lane_enable_n} = ln;
        data_bus = w ? d : ~data_bus;  // A read leaves the lines to the flash
        for (int i = 0; i < 2; i++) begin
            @(posedge ref_clk); #1;
            bus_ready_n = (i == 0);
            #2;
            if (i == 0) snap_wait = obs;
        end
        snap_rdy = obs;
        @(posedge ref_clk); #1;
        {bus_ready_n, page_port_select_n, window_select_n} = 3'h7;
        {upper_lane_enable_n, lower_lane_enable_n} = 2'h3;
        data_bus = ~data_bus;          // Released lines do not keep old value
        #2;
        snap_after = obs;
        if (win && !w && rec) repeat (FLOAT + 1) @(posedge ref_clk);
    endtask : cycle
endmodule : pfw_cpu_model
`default_nettype wire

/* dv/tb.sv */
// Self-checking bench for the flash window glue, driven by the bus model.
// Assumes pfw_pkg and pfw_glue compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import pfw_pkg::*;
    typedef struct packed {
        logic win; logic w; logic [1:0] ln; logic [7:0] d;
        logic [6:0] ew; logic [6:0] er; logic [7:0] pg;
    } pfw_row_t;                       // Inputs beside expected snapshots and page
    logic ref_clk, rst_b, asn, wnr, rdy_n, ul_n, ll_n, pps_n, ws_n;
    logic we_n, ue_n, le_n, buf_n, oc_n, lclk, drv;
    logic [15:0] db;
    logic [6:0]  obs, s_w, s_r, s_a;
    pfw_page_t   pg;
    int n_fail = 0;
    int samples_checked = 0;
    // Order: strobe, upper, lower, buffer, latch clock, drive, output control
    assign obs = {we_n, ue_n, le_n, buf_n, lclk, drv, oc_n};
    localparam pfw_row_t ROWS [9] = '{
        '{1'h0, 1'h1, 2'h0, 8'h5A, 7'h7D, 7'h79, 8'h5A},  // Page write
        '{1'h1, 1'h1, 2'h0, 8'h11, 7'h02, 7'h42, 8'h5A},  // Window write, both lanes
        '{1'h1, 1'h1, 2'h1, 8'h22, 7'h12, 7'h52, 8'h5A},  // Upper lane only
        '{1'h1, 1'h1, 2'h2, 8'h33, 7'h22, 7'h62, 8'h5A},  // Lower lane only
        '{1'h0, 1'h1, 2'h3, 8'hA5, 7'h7D, 7'h79, 8'hA5},  // Page write, no lanes
        '{1'h0, 1'h0, 2'h0, 8'h44, 7'h79, 7'h79, 8'hA5},  // Page port read
        '{1'h1, 1'h0, 2'h0, 8'h55, 7'h42, 7'h42, 8'hA5},  // Window read
        '{1'h0, 1'h1, 2'h0, 8'h00, 7'h7D, 7'h79, 8'h00},  // Lowest page
        '{1'h0, 1'h1, 2'h0, 8'hFF, 7'h7D, 7'h79, 8'hFF}}; // Highest page
    ////////////////////////////////////////////////////////////////////////
    pfw_glue #(.FLOAT_CYC(4)) pfw_glue_i (.ref_clk(ref_clk), .rst_b(rst_b),
        .addr_strobe_n(asn), .write_not_read(wnr), .bus_ready_n(rdy_n),
        .upper_lane_enable_n(ul_n), .lower_lane_enable_n(ll_n),
        .page_port_select_n(pps_n), .window_select_n(ws_n), .data_bus(db),
        .flash_write_strobe_n(we_n), .upper_device_enable_n(ue_n),
        .lower_device_enable_n(le_n), .buffer_enable_n(buf_n),
        .latch_output_control_n(oc_n), .latch_clock(lclk),
        .upper_flash_addr(pg), .upper_addr_drive(drv));
    pfw_cpu_model #(.FLOAT(4)) pfw_cpu_model_i (.ref_clk(ref_clk), .obs(obs),
        .addr_strobe_n(asn), .write_not_read(wnr), .bus_ready_n(rdy_n),
        .upper_lane_enable_n(ul_n), .lower_lane_enable_n(ll_n),
        .page_port_select_n(pps_n), .window_select_n(ws_n), .data_bus(db),
        .snap_wait(s_w), .snap_rdy(s_r), .snap_after(s_a));
    ////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    // Reset for 8 cycles, then everything must be idle with page zero
    task automatic do_reset();
        @(posedge ref_clk); #1;
        rst_b = 1'b0;
        repeat (8) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        check("idle", {1'b0, obs}, 8'h79);
        check("page", pg, 8'h00);
    endtask : do_reset
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // Watchdog well beyond the expected run
    initial begin
        #(4 * 3000);
        n_fail++;
        stop_test();
    end
    initial begin
        rst_b = 1'b0;
        do_reset();
        foreach (ROWS[i]) begin
            pfw_cpu_model_i.cycle(ROWS[i].win, ROWS[i].w, ROWS[i].ln,
                                  {8'hC3, ROWS[i].d}, 1'b1);
            check("wait", {1'b0, s_w}, {1'b0, ROWS[i].ew});
            check("ready", {1'b0, s_r}, {1'b0, ROWS[i].er});
            check("after", {1'b0, s_a}, 8'h79);
            check("page", pg, ROWS[i].pg);
            $display("row %0d done", i);
        end
        // Window read then a page write squeezed into the float gap
        pfw_cpu_model_i.cycle(1'b1, 1'b0, 2'h0, 16'h0000, 1'b0);
        pfw_cpu_model_i.cycle(1'b0, 1'b1, 2'h0, 16'h003C, 1'b1);
        check("refused", {1'b0, s_w}, 8'h79);
        check("kept", pg, 8'hFF);
        $display("refusal test done");
        do_reset();
        $display("second reset done");
        stop_test();
    end
endmodule : tb
`default_nettype wire
